// >>> hw/sesc_cmd.sv
// Set service enable state command interpreter with service gating
`timescale 1ns/10ps
module sesc_cmd import sesc_pkg::*; #(
	parameter int          NUM_SVC      = 32,
	parameter logic [31:0] RESET_ENABLE = 32'hFFFFFFFF
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	// Request stream
	input  wire sesc_byte_t        req,
	output      logic              reqReady,
	// Response stream
	output      sesc_byte_t        rsp,
	input  wire logic              rspReady,
	// Service gating
	input  wire logic [NUM_SVC-1:0] userAccess,
	output      logic [NUM_SVC-1:0] svcEnabled,
	output      logic [NUM_SVC-1:0] svcRun
);

	// Refuse sizes that the 32 bit maps and fixed frames cannot serve
	if (NUM_SVC < 1 || NUM_SVC > MAX_SVC) begin : g_bad_num_svc
		$error("NUM_SVC must lie between 1 and 32");
	end
	if (OP_MSB - OP_LSB != 1) begin : g_bad_op_field
		$error("The operation field must be two bits wide");
	end
	if (REQ_LEN != int'(IDX_MASK3) + 1) begin : g_bad_req_len
		$error("Request length must end on the last mask byte");
	end
	if (RSP_LEN != int'(RSP_LAST_IDX) + 1) begin : g_bad_rsp_len
		$error("Response length must end on the last sent byte");
	end

	// Bits of the 32 bit maps that stand for implemented services
	function automatic logic [31:0] implMask();
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < MAX_SVC; i++) begin
			if (i < NUM_SVC) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	// New enable state for a given operation, or the old one when refused
	function automatic logic [31:0] applyOp(logic [31:0] cur,
	                                        logic [31:0] sel,
	                                        logic [1:0]  op);
		logic [31:0] res;
		res = cur;
		case (op)
			OP_ENABLE:  res = cur | sel;
			OP_DISABLE: res = cur & ~sel;
			default:    res = cur;
		endcase
		return res;
	endfunction

	// Only enable and disable are defined operations
	function automatic logic opKnown(logic [1:0] op);
		return (op == OP_ENABLE) || (op == OP_DISABLE);
	endfunction

	// Completion code: a bad length outranks a bad id, which outranks
	// an undefined operation; every fault leaves the state alone
	function automatic logic [7:0] completion(logic       lenErr,
	                                          logic [7:0] extId,
	                                          logic [1:0] op);
		logic [7:0] cc;
		cc = CC_OK;
		if (lenErr) begin
			cc = CC_BAD_LEN;
		end else if (extId != EXT_ID) begin
			cc = CC_BAD_FIELD;
		end else if (!opKnown(op)) begin
			cc = CC_BAD_FIELD;
		end
		return cc;
	endfunction

	// Files one request byte by its position; any byte past the sixth
	// only marks the frame as too long
	function automatic sesc_core_t storeReqByte(sesc_core_t c,
	                                            logic [7:0] d);
		sesc_core_t r;
		r = c;
		case (c.cnt)
			IDX_EXT_ID:       r.extId       = d;
			IDX_OP:           r.opByte      = d;
			// Mask gathered least significant byte first
			IDX_MASK0:        r.mask[7:0]   = d;
			IDX_MASK0 + 3'h1: r.mask[15:8]  = d;
			IDX_MASK3 - 3'h1: r.mask[23:16] = d;
			IDX_MASK3:        r.mask[31:24] = d;
			default:          r.lenErr      = 1'b1;
		endcase
		// The position saturates so that a long frame cannot wrap round
		if (c.cnt != IDX_FULL) begin
			r.cnt = c.cnt + 3'h1;
		end
		return r;
	endfunction

	// Answer frame, first byte in the low bits: completion code, echoed
	// id, then the resulting state of present services
	function automatic logic [47:0] respFrame(logic [31:0] state,
	                                          logic [7:0]  cc);
		return {state & implMask(), EXT_ID, cc};
	endfunction

	// Forgets the finished request, so a short one that follows sees zeros
	function automatic sesc_core_t clearReq(sesc_core_t c);
		sesc_core_t r;
		r        = c;
		r.st     = ST_RECEIVE;
		r.cnt    = 3'h0;
		r.lenErr = 1'b0;
		r.extId  = 8'h00;
		r.opByte = 8'h00;
		r.mask   = '0;
		return r;
	endfunction

	// Control state and its next value
	sesc_core_t  coreReg;
	sesc_core_t  coreNext;

	// Handshakes and the decoded request
	logic        serDone;
	logic        accept;
	logic [1:0]  opCode;
	logic [7:0]  ccode;
	logic [31:0] newState;

	// Bytes are taken only while a request is being gathered
	assign reqReady = (coreReg.st == ST_RECEIVE);
	assign accept   = req.valid & reqReady;
	assign opCode   = coreReg.opByte[OP_MSB:OP_LSB];
	assign ccode    = completion(coreReg.lenErr, coreReg.extId, opCode);

	// Refused requests keep the old state
	always_comb begin
		newState = coreReg.enable;
		if (ccode == CC_OK) begin
			newState = applyOp(coreReg.enable,
			                   coreReg.mask & implMask(), opCode);
		end
	end

	// Receive gathers the frame, execute applies the operation exactly
	// once, respond waits for the serializer to hand over the last byte;
	// only then is the next request taken
	always_comb begin
		coreNext       = coreReg;
		coreNext.start = 1'b0;
		case (coreReg.st)
			ST_RECEIVE: begin
				if (accept) begin
					coreNext = storeReqByte(coreNext, req.data);
					if (req.last) begin
						if (coreReg.cnt != IDX_MASK3) begin
							coreNext.lenErr = 1'b1;
						end
						coreNext.st = ST_EXECUTE;
					end
				end
			end
			ST_EXECUTE: begin
				coreNext.enable  = newState;
				// Completion code, echo id, then resulting state LSB first
				coreNext.payload = respFrame(newState, ccode);
				coreNext.start   = 1'b1;
				coreNext.st      = ST_RESPOND;
			end
			ST_RESPOND: begin
				if (serDone) begin
					coreNext = clearReq(coreNext);
				end
			end
			default: coreNext.st = ST_RECEIVE;
		endcase
	end

	// Reset loads the configured enable state and an idle receiver
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			coreReg        <= '0;
			coreReg.st     <= ST_RECEIVE;
			coreReg.enable <= RESET_ENABLE;
		end else begin
			coreReg <= coreNext;
		end
	end

	// Sends the six answer bytes, one per taken handshake
	sesc_rsp_ser u_ser (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.start    (coreReg.start),
		.payload  (coreReg.payload),
		.done     (serDone),
		.rsp      (rsp),
		.rspReady (rspReady)
	);

	// Disabled services are held off; enabled ones obey user access
	assign svcEnabled = coreReg.enable[NUM_SVC-1:0];
	assign svcRun     = coreReg.enable[NUM_SVC-1:0] & userAccess;

endmodule

// >>> hw/sesc_pkg.sv
// Shared constants and types for the service enable state command block
package sesc_pkg;

	// Request and response framing
	localparam logic [7:0] EXT_ID        = 8'h02;
	localparam int         REQ_LEN       = 6;
	localparam int         RSP_LEN       = 6;
	localparam int         MAX_SVC       = 32;
	localparam int         OP_MSB        = 7;
	localparam int         OP_LSB        = 6;

	// Byte positions within the request and response (zero based)
	localparam logic [2:0] IDX_EXT_ID    = 3'h0;
	localparam logic [2:0] IDX_OP        = 3'h1;
	localparam logic [2:0] IDX_MASK0     = 3'h2;
	localparam logic [2:0] IDX_MASK3     = 3'h5;
	localparam logic [2:0] IDX_FULL      = 3'h6;
	localparam logic [2:0] RSP_LAST_IDX  = 3'h5;

	// Operation codes
	localparam logic [1:0] OP_ENABLE     = 2'h0;
	localparam logic [1:0] OP_DISABLE    = 2'h1;

	// Completion codes
	localparam logic [7:0] CC_OK         = 8'h00;
	localparam logic [7:0] CC_BAD_FIELD  = 8'hCC;
	localparam logic [7:0] CC_BAD_LEN    = 8'hC7;

	// Byte stream carrier, used for request and response alike
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} sesc_byte_t;

	typedef enum logic [1:0] {
		ST_RECEIVE = 2'b00,
		ST_EXECUTE = 2'b01,
		ST_RESPOND = 2'b10
	} sesc_state_t;

	typedef struct packed {
		sesc_state_t st;
		logic [2:0]  cnt;
		logic        lenErr;
		logic [7:0]  extId;
		logic [7:0]  opByte;
		logic [31:0] mask;
		logic [31:0] enable;
		logic        start;
		logic [47:0] payload;
	} sesc_core_t;

	typedef struct packed {
		logic        active;
		logic [2:0]  idx;
		logic [47:0] shifter;
	} sesc_ser_t;

endpackage

// >>> hw/sesc_rsp_ser.sv
// Response serializer: sends a six byte answer, first byte in the low bits
`timescale 1ns/10ps
module sesc_rsp_ser import sesc_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// Load side
	input  wire logic        start,
	input  wire logic [47:0] payload,
	output      logic        done,
	// Response stream
	output      sesc_byte_t  rsp,
	input  wire logic        rspReady
);

	sesc_ser_t serReg;
	sesc_ser_t serNext;
	logic      take;

	assign take = serReg.active & rspReady;
	assign done = take & (serReg.idx == RSP_LAST_IDX);

	always_comb begin
		serNext = serReg;
		if (start && !serReg.active) begin
			serNext.active  = 1'b1;
			serNext.idx     = 3'h0;
			serNext.shifter = payload;
		end else if (take) begin
			serNext.shifter = {8'h00, serReg.shifter[47:8]};
			serNext.idx     = serReg.idx + 3'h1;
			if (serReg.idx == RSP_LAST_IDX) begin
				serNext.active = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serReg <= '0;
		end else begin
			serReg <= serNext;
		end
	end

	assign rsp.valid = serReg.active;
	assign rsp.data  = serReg.shifter[7:0];
	assign rsp.last  = serReg.active & (serReg.idx == RSP_LAST_IDX);

endmodule

// >>> testbench/sesc_client.sv
// Client model: sends requests and drains answers
`timescale 1ns/10ps
module sesc_client import sesc_pkg::*; (
	// Clock
	input  wire logic       ref_clk,
	// Streams
	output      sesc_byte_t req,
	input  wire logic       reqReady,
	input  wire sesc_byte_t rsp,
	output      logic       rspReady
);
	logic       slow = 1'b0;
	logic [7:0] rx [6];
	initial req = '0;
	initial rspReady = 1'b0;
	// A slow sink takes a byte every other cycle
	always @(posedge ref_clk) rspReady <= !slow || !rspReady;
	task automatic cmd(input logic [7:0] id, op, input logic [31:0] m,
			input int n);
		logic [7:0] b [7];
		b = '{id, op, m[7:0], m[15:8], m[23:16], m[31:24], 8'hA5};
		for (int i = 0; i < n; i++) begin
			req <= '{1'b1, b[i], i == n - 1};
			do @(posedge ref_clk); while (!reqReady);
		end
		req <= '{1'b0, ~req.data, 1'b0};
		foreach (rx[k]) begin
			do @(posedge ref_clk); while (!(rsp.valid && rspReady));
			rx[k] = rsp.data;
		end
	endtask
endmodule

// >>> testbench/sesc_cmd_sva.sv
// Assertion checker on the command block ports
`timescale 1ns/10ps
module sesc_cmd_sva import sesc_pkg::*; #(parameter int NUM_SVC = 32) (
	// Watched ports
	input wire logic               ref_clk,
	input wire logic               reset_n,
	input wire sesc_byte_t         req,
	input wire logic               reqReady,
	input wire sesc_byte_t         rsp,
	input wire logic               rspReady,
	input wire logic [NUM_SVC-1:0] userAccess,
	input wire logic [NUM_SVC-1:0] svcEnabled,
	input wire logic [NUM_SVC-1:0] svcRun
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_run_gate: assert property (
		svcRun == (svcEnabled & userAccess)) else $error("bad gating");
	a_answer_delay: assert property (
		req.valid && req.last && reqReady |-> ##3 rsp.valid)
		else $error("late answer");
	a_echo_id: assert property (
		$rose(rsp.valid) && rspReady |=> rsp.data == EXT_ID)
		else $error("bad id echo");
	a_keep_idle: assert property (
		reqReady |=> $stable(svcEnabled)) else $error("state moved");
	a_keep_answer: assert property (
		rsp.valid |-> $stable(svcEnabled)) else $error("state moved");
	a_last_state: assert property (
		rsp.valid && rsp.last |-> rsp.data == 8'(svcEnabled >> 24))
		else $error("bad state byte");
	a_rsp_hold: assert property (
		rsp.valid && !rspReady |=> rsp.valid && $stable(rsp.data))
		else $error("byte dropped");
	a_busy_rsp: assert property (
		rsp.valid |-> !reqReady) else $error("taking while busy");
	c_slow: cover property (rsp.valid && !rspReady);
	c_done: cover property (rsp.last && rspReady);
	c_error: cover property ($rose(rsp.valid) && rsp.data == CC_BAD_FIELD);
endmodule

// >>> testbench/sesc_cmd_tb_top.sv
// Testbench for the service enable state command block
`timescale 1ns/10ps
module sesc_cmd_tb_top import sesc_pkg::*; ;
	typedef struct packed {
		logic [7:0]  op;
		logic [31:0] mask;
		logic [7:0]  cc;
		logic [31:0] st;
	} sesc_row_t;
	logic        ref_clk;
	logic        reset_n;
	logic        rspReady;
	logic        reqReady;
	logic [31:0] userAccess;
	logic [31:0] svcEnabled;
	logic [31:0] svcRun;
	sesc_byte_t  req;
	sesc_byte_t  rsp;
	int          n_errors = 0;
	int          n_checks = 0;
	sesc_row_t   rows [6] = '{
		'{8'h40, 32'h0000_00FF, CC_OK, 32'hFFFF_FF00},
		'{8'h3F, 32'h0000_000F, CC_OK, 32'hFFFF_FF0F},
		'{8'h40, 32'h8000_0001, CC_OK, 32'h7FFF_FF0E},
		'{8'h80, 32'hFFFF_FFFF, CC_BAD_FIELD, 32'h7FFF_FF0E},
		'{8'hC0, 32'hFFFF_FFFF, CC_BAD_FIELD, 32'h7FFF_FF0E},
		'{8'h00, 32'h8000_0000, CC_OK, 32'hFFFF_FF0E}};
	sesc_cmd sesc_cmd_i (.ref_clk, .reset_n, .req, .reqReady, .rsp,
		.rspReady, .userAccess, .svcEnabled, .svcRun);
	sesc_client sesc_client_i (.ref_clk, .req, .reqReady, .rsp, .rspReady);
	task automatic check(input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic answer(input logic [7:0] id, op, input logic [31:0] m,
			input int n, input logic [7:0] cc, input logic [31:0] st);
		logic [7:0] r [6];
		sesc_client_i.cmd(id, op, m, n);
		r = sesc_client_i.rx;
		check(32'(r[0]), 32'(cc));
		check(32'(r[1]), 32'(EXT_ID));
		check({r[5], r[4], r[3], r[2]}, st);
		check(svcEnabled, st);
		check(svcRun, st & userAccess);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		reset_n = 1'b0;
		userAccess = 32'h0F0F_33FF;
		repeat (2) @(posedge ref_clk);
		check(svcEnabled, 32'hFFFF_FFFF);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			sesc_client_i.slow <= i[0];
			userAccess <= ~rows[i].mask;
			answer(EXT_ID, rows[i].op, rows[i].mask, REQ_LEN,
				rows[i].cc, rows[i].st);
		end
		answer(8'h03, 8'h40, '1, REQ_LEN, CC_BAD_FIELD, 32'hFFFF_FF0E);
		answer(EXT_ID, 8'h40, 32'hFF, 5, CC_BAD_LEN,
			32'hFFFF_FF0E);
		answer(EXT_ID, 8'h40, 32'hFF, 7, CC_BAD_LEN,
			32'hFFFF_FF0E);
		// Reset in mid-run brings back the configured enable state
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(svcEnabled, 32'hFFFF_FFFF);
		check(32'({reqReady, rsp.valid}), 32'h0000_0002);
		reset_n <= 1'b1;
		answer(EXT_ID, 8'h40, 32'h0000_00F0, REQ_LEN, CC_OK,
			32'hFFFF_FF0F);
		complete_run();
	end
	initial begin
		#50000;
		n_errors++;
		complete_run();
	end
endmodule
bind sesc_cmd sesc_cmd_sva #(.NUM_SVC(NUM_SVC)) sesc_cmd_sva_i (.ref_clk,
	.reset_n, .req, .reqReady, .rsp, .rspReady, .userAccess, .svcEnabled,
	.svcRun);
